// ### src/prmc_pkg.sv
package prmc_pkg;
  localparam int unsigned CLK_MHZ    = 100;
  localparam int unsigned START_MS   = 1000;
  localparam int unsigned PF_ALLOW_MS = 10;
  localparam int unsigned WDT_MS     = 200;
  localparam int unsigned CYC_PER_MS = 1000 * CLK_MHZ;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_OUTIMG = 8'h08;
  localparam logic [7:0] OFS_CMD    = 8'h0C;
  localparam logic [7:0] OFS_EXTOUT = 8'h10;
  // Control fields
  localparam int CTL_MODE_LO = 0;
  localparam int CTL_OUTMODE = 2;
  localparam int CTL_SFC     = 3;
  // Command bits, write one to act
  localparam int CMD_STEP = 0;
  localparam int CMD_LCLR = 1;
  localparam int CMD_ACLR = 2;
  localparam int CMD_WCLR = 3;
  localparam int OUT_W = 16;
  localparam logic [3:0] CTRL_RST = 4'h1;

  typedef enum logic [1:0] {
    OP_RUN   = 2'b00,
    OP_STOP  = 2'b01,
    OP_PAUSE = 2'b10,
    OP_STEP  = 2'b11
  } prmc_op_t;

  typedef enum logic [2:0] {
    ST_INIT  = 3'b000,
    ST_STOP  = 3'b001,
    ST_START = 3'b010,
    ST_RUN   = 3'b011,
    ST_DRAIN = 3'b100,
    ST_PAUSE = 3'b101,
    ST_STEP  = 3'b110,
    ST_PFAIL = 3'b111
  } prmc_state_t;

  // Key switch positions
  typedef struct packed {
    logic run;
    logic stop;
    logic rst;
    logic lclr;
  } prmc_key_t;

  // Data area clear strobes
  typedef struct packed {
    logic general;
    logic latch_a;
    logic latch_b;
    logic fault;
  } prmc_clr_t;
endpackage

// ### src/prmc_ctrl.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module prmc_ctrl #(
  parameter int unsigned START_CYC = prmc_pkg::START_MS * prmc_pkg::CYC_PER_MS,
  parameter int unsigned PF_CYC    = prmc_pkg::PF_ALLOW_MS * prmc_pkg::CYC_PER_MS,
  parameter int unsigned WDT_CYC   = prmc_pkg::WDT_MS * prmc_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Key switch, supply and program engine
  input  wire prmc_pkg::prmc_key_t         key,
  input  wire logic                        pf_detect,
  input  wire logic                        supply_ok,
  input  wire logic                        scan_end,
  // Control towards engine and I/O
  output logic [1:0]                       op_mode,
  output logic                             exec_en,
  output logic                             restart,
  output logic                             step_go,
  output logic                             timer_en,
  output logic                             io_refresh_en,
  output logic [prmc_pkg::OUT_W-1:0]       ext_out,
  output prmc_pkg::prmc_clr_t              clr,
  output logic                             init_io,
  output logic                             prep,
  output logic                             save_file,
  output logic                             sys_save,
  output logic                             wdt_err
);
  import prmc_pkg::*;

  prmc_state_t        state_reg, state_next, ret_reg;
  logic [3:0]         ctrl_reg;
  logic [OUT_W-1:0]   img_reg, saved_reg, ext_reg;
  logic [31:0]        cnt_reg, wdt_reg;
  logic               first_reg, wdt_err_reg;
  logic               pready_reg, pslverr_reg;
  logic [31:0]        prdata_reg;
  prmc_clr_t          clr_reg;
  logic               restart_reg, step_reg, init_reg, prep_reg;
  logic               save_reg, sys_reg;

  // Bus decode
  wire       acc     = psel & penable & ~pready_reg;
  wire       wr      = acc & pwrite;
  wire       hit_ctl = paddr == OFS_CTRL;
  wire       hit_st  = paddr == OFS_STATUS;
  wire       hit_img = paddr == OFS_OUTIMG;
  wire       hit_cmd = paddr == OFS_CMD;
  wire       hit_ext = paddr == OFS_EXTOUT;
  wire       mapped  = hit_ctl | hit_st | hit_img | hit_cmd | hit_ext;
  wire       cmd_wr  = wr & hit_cmd;
  wire       wdt_clr = cmd_wr & pwdata[CMD_WCLR];
  wire       cmd_stp = cmd_wr & pwdata[CMD_STEP];
  wire       rem_lc  = cmd_wr & pwdata[CMD_LCLR];
  wire       rem_ac  = cmd_wr & pwdata[CMD_ACLR];
  wire [1:0] rem_mode = ctrl_reg[CTL_MODE_LO +: 2];

  // Key stop and a watchdog fault beat the remote request
  wire       wdt_hit = (wdt_reg == WDT_CYC - 1);
  wire       force_stop = key.stop | ~key.run | wdt_err_reg | wdt_hit;
  wire [1:0] des = force_stop ? OP_STOP : rem_mode;

  // Program owns the output image only while executing
  wire img_ok = (state_reg == ST_RUN) | (state_reg == ST_DRAIN)
              | (state_reg == ST_STEP);
  wire pf_in   = pf_detect & (state_reg != ST_PFAIL) & (state_reg != ST_INIT);
  wire pf_long = cnt_reg >= PF_CYC;
  wire start_done = cnt_reg >= START_CYC - 1;
  wire enter_stop = (state_next == ST_STOP) & (state_reg != ST_STOP);
  wire enter_run  = (state_next == ST_RUN) & (state_reg == ST_START);
  wire enter_init = state_next == ST_INIT;

  // Outage entry reports the status being left, not a stale return point
  prmc_state_t        ret_now;
  assign ret_now = pf_in ? state_reg : ret_reg;

  // Return point passed in, so every caller sees it change
  function automatic prmc_op_t mode_of(input prmc_state_t s, input prmc_state_t r);
    unique case (s)
      ST_RUN, ST_DRAIN, ST_START: mode_of = OP_RUN;
      ST_PAUSE:                   mode_of = OP_PAUSE;
      ST_STEP:                    mode_of = OP_STEP;
      ST_INIT, ST_STOP:           mode_of = OP_STOP;
      ST_PFAIL:                   mode_of = mode_of_ret(r);
    endcase
  endfunction

  function automatic prmc_op_t mode_of_ret(input prmc_state_t s);
    unique case (s)
      ST_PAUSE:                   mode_of_ret = OP_PAUSE;
      ST_STEP:                    mode_of_ret = OP_STEP;
      ST_STOP, ST_INIT, ST_PFAIL: mode_of_ret = OP_STOP;
      ST_RUN, ST_DRAIN, ST_START: mode_of_ret = OP_RUN;
    endcase
  endfunction

  // Next state; one state active at a time
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_INIT:  state_next = ST_STOP;
      ST_STOP:  if (des != OP_STOP) state_next = ST_START;
      ST_START: begin
        if (des == OP_STOP) state_next = ST_STOP;
        else if (start_done) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (wdt_hit | wdt_err_reg) state_next = ST_STOP;
        else if (des == OP_STOP) state_next = ST_DRAIN;
        else if (des == OP_PAUSE) state_next = ST_PAUSE;
        else if (des == OP_STEP) state_next = ST_STEP;
      end
      ST_DRAIN: if (scan_end | wdt_hit) state_next = ST_STOP;
      ST_PAUSE, ST_STEP: begin
        if (des == OP_STOP) state_next = ST_STOP;
        else if (des == OP_RUN) state_next = ST_RUN;
        else if (des == OP_PAUSE) state_next = ST_PAUSE;
        else state_next = ST_STEP;
      end
      ST_PFAIL: if (supply_ok) begin
        // A watchdog trip during the outage must not resume execution
        if (pf_long) state_next = ST_INIT;
        else if (wdt_hit | wdt_err_reg) state_next = ST_STOP;
        else state_next = ret_reg;
      end
    endcase
    if (pf_in) state_next = ST_PFAIL;
    if (key.rst) state_next = ST_INIT;
  end

  // State, return point and shared counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_INIT;
      ret_reg   <= ST_STOP;
      cnt_reg   <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (pf_in) ret_reg <= state_reg;
      if (state_next != state_reg) cnt_reg <= 32'h0000_0000;
      else if (~&cnt_reg) cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  // Watchdog runs on through an outage, so outage time adds to the scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_reg     <= 32'h0000_0000;
      wdt_err_reg <= 1'b0;
    end else begin
      if (scan_end | ~(img_ok | (state_reg == ST_PFAIL)) | wdt_hit)
        wdt_reg <= 32'h0000_0000;
      else
        wdt_reg <= wdt_reg + 32'h0000_0001;
      if (wdt_hit) wdt_err_reg <= 1'b1; // Set wins over clear
      else if (wdt_clr) wdt_err_reg <= 1'b0;
    end
  end

  // Control and output image registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      img_reg  <= '0;
    end else begin
      if (wr & hit_ctl) ctrl_reg <= pwdata[3:0];
      if (enter_run) img_reg <= saved_reg;
      else if (wr & hit_img & img_ok) img_reg <= pwdata[OUT_W-1:0];
      else if (enter_init) img_reg <= '0;
    end
  end

  // External outputs: saved and forced off at stop, held in pause and outage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_reg   <= '0;
      saved_reg <= '0;
      first_reg <= 1'b0;
    end else if (enter_init) begin
      ext_reg   <= '0;
      saved_reg <= '0;
    end else if (enter_stop) begin
      saved_reg <= img_reg;
      ext_reg   <= '0;
    end else if (enter_run) begin
      // Mode bit set: hold outputs off until the first scan ends
      ext_reg   <= ctrl_reg[CTL_OUTMODE] ? '0 : saved_reg;
      first_reg <= ctrl_reg[CTL_OUTMODE];
    end else if (pf_in) begin
      // Outage freezes the points at once, even mid-scan
      ext_reg   <= ext_reg;
    end else if ((state_reg == ST_RUN) | (state_reg == ST_DRAIN)) begin
      if (scan_end) first_reg <= 1'b0;
      if (!first_reg | scan_end) ext_reg <= img_reg;
    end else if ((state_reg == ST_STEP) & step_reg) begin
      ext_reg <= img_reg;
    end
  end

  // Strobes towards engine and memory, one cycle long except those that follow a held key.rst or key.lclr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_reg <= 1'b0;
      step_reg    <= 1'b0;
      init_reg    <= 1'b0;
      prep_reg    <= 1'b0;
      save_reg    <= 1'b0;
      sys_reg     <= 1'b0;
      clr_reg     <= '0;
    end else begin
      restart_reg <= enter_run | (state_reg == ST_RUN & scan_end);
      step_reg    <= cmd_stp & (state_reg == ST_STEP);
      init_reg    <= enter_init;
      prep_reg    <= enter_init | ((state_reg == ST_STOP) & (state_next == ST_START));
      save_reg    <= pf_in;
      sys_reg     <= pf_in & ctrl_reg[CTL_SFC];
      clr_reg.general <= enter_init | rem_ac;
      clr_reg.latch_a <= key.lclr | rem_lc | rem_ac;
      clr_reg.latch_b <= rem_ac;
      clr_reg.fault   <= key.lclr | rem_lc;
    end
  end

  // Read data mux; unmapped addresses answer with an error
  wire [31:0] rd_mux =
      hit_ctl ? {28'h0, ctrl_reg}
    : hit_st  ? {26'h0, state_reg, wdt_err_reg, mode_of(state_reg, ret_reg)}
    : hit_img ? {16'h0, img_reg}
    : hit_ext ? {16'h0, ext_reg}
    : 32'h0000_0000;

  // One wait state per transfer keeps read data a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc & ~mapped;
      prdata_reg  <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Output drive, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_mode       <= OP_STOP;
      exec_en       <= 1'b0;
      timer_en      <= 1'b0;
      io_refresh_en <= 1'b0;
    end else begin
      op_mode  <= mode_of(state_next, ret_now);
      exec_en  <= (state_next == ST_RUN) | (state_next == ST_DRAIN);
      // Timers keep counting through a short outage
      timer_en <= (state_next == ST_RUN) | (state_next == ST_DRAIN)
                | (state_next == ST_PFAIL);
      io_refresh_en <= (state_next != ST_INIT) & (state_next != ST_PFAIL);
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign restart   = restart_reg;
  assign step_go   = step_reg;
  assign ext_out   = ext_reg;
  assign clr       = clr_reg;
  assign init_io   = init_reg;
  assign prep      = prep_reg;
  assign save_file = save_reg;
  assign sys_save  = sys_reg;
  assign wdt_err   = wdt_err_reg;

  // Checks
  property p_stop_off;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_STOP) |-> (ext_reg == '0);
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("outputs on in stop");

  property p_drain;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_DRAIN && !scan_end && !wdt_hit && !pf_in && !key.rst)
      |=> (state_reg == ST_DRAIN) && exec_en;
  endproperty
  a_drain: assert property (p_drain) else $error("stopped before scan end");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_START && state_next == ST_RUN) |=> restart_reg ##0 exec_en;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart at run entry");

  property p_pause_hold;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_PAUSE) [*2] |-> $stable(ext_reg) && !exec_en;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause not holding");

  property p_pf_save;
    @(posedge pclk) disable iff (!presetn)
      (pf_in && !key.rst) |=> save_reg && (sys_reg == $past(ctrl_reg[CTL_SFC]))
      && $stable(ext_reg) && timer_en;
  endproperty
  a_pf_save: assert property (p_pf_save) else $error("outage entry wrong");

  property p_reset_clear;
    @(posedge pclk) disable iff (!presetn)
      (key.rst && !rem_ac) |=> clr_reg.general && !clr_reg.latch_b && init_reg;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset clear wrong");

  property p_lclr;
    @(posedge pclk) disable iff (!presetn)
      (key.lclr && !rem_ac) |=> clr_reg.latch_a && clr_reg.fault && !clr_reg.latch_b;
  endproperty
  a_lclr: assert property (p_lclr) else $error("latch clear wrong");

  property p_prep;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_STOP && state_next == ST_START) |=> prep_reg && !init_reg;
  endproperty
  a_prep: assert property (p_prep) else $error("stop to run prep wrong");

  property p_wdt;
    @(posedge pclk) disable iff (!presetn)
      wdt_hit |=> wdt_err_reg && (state_reg != ST_RUN);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not latched");

  property p_start_idle;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_START) |-> !exec_en;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("exec in start delay");

  property p_scan_wrap;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_RUN && scan_end && state_next == ST_RUN) |=> restart_reg && exec_en;
  endproperty
  a_scan_wrap: assert property (p_scan_wrap) else $error("no wrap to step 0");

  property p_run_out;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_START && state_next == ST_RUN)
      |=> ext_reg == ($past(ctrl_reg[CTL_OUTMODE]) ? {OUT_W{1'b0}} : $past(saved_reg));
  endproperty
  a_run_out: assert property (p_run_out) else $error("run entry outputs wrong");

  property p_step_hold;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_STEP && state_next == ST_STEP && !step_reg)
      |=> $stable(ext_reg) && !exec_en;
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("step not holding");

  property p_refresh;
    @(posedge pclk) disable iff (!presetn)
      (state_reg inside {ST_RUN, ST_STOP, ST_PAUSE} && !pf_in && !key.rst) |=> io_refresh_en;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh stopped");

  property p_pf_resume;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_PFAIL && supply_ok && !pf_long && !wdt_hit && !wdt_err_reg && !key.rst)
      |=> state_reg == $past(ret_reg);
  endproperty
  a_pf_resume: assert property (p_pf_resume) else $error("no resume after outage");

  property p_pf_long;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_PFAIL && supply_ok && pf_long) |=> init_reg && clr_reg.general;
  endproperty
  a_pf_long: assert property (p_pf_long) else $error("long outage no restart");

endmodule // prmc_ctrl
`default_nettype wire

// ### dv/prmc_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module prmc_engine_model #(
  parameter int unsigned SCAN_CYC = 40
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Controller side
  input  wire logic exec_en,
  input  wire logic restart,
  input  wire logic hang,
  output logic      scan_end
);
  logic [7:0] cnt_reg;
  logic       end_reg;
  // Scan runs step 0 to terminator; hang models a runaway scan for the watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
      end_reg <= 1'b0;
    end else begin
      end_reg <= 1'b0;
      if (restart) begin
        cnt_reg <= 8'h00;
      end else if (exec_en && !hang) begin
        end_reg <= (cnt_reg == 8'(SCAN_CYC - 1));
        cnt_reg <= (cnt_reg == 8'(SCAN_CYC - 1)) ? 8'h00 : cnt_reg + 8'h01;
      end
    end
  end
  assign scan_end = end_reg;
endmodule // prmc_engine_model
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import prmc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pf_detect = 1'b0, supply_ok = 1'b1, scan_end, hang = 1'b0;
  prmc_key_t key = 4'h0;
  prmc_clr_t clr;
  logic [1:0] op_mode;
  logic exec_en, restart, step_go, timer_en, io_refresh_en, init_io, prep;
  logic save_file, sys_save, wdt_err;
  logic [15:0] ext_out;
  logic [9:0] seen = 10'h000;
  logic seen_clr = 1'b0;
  int errors = 0, n_compared = 0;
  // Short counts keep the run brief
  prmc_ctrl #(.START_CYC(20), .PF_CYC(30), .WDT_CYC(200)) prmc_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key(key), .pf_detect(pf_detect), .supply_ok(supply_ok), .scan_end(scan_end),
    .op_mode(op_mode), .exec_en(exec_en), .restart(restart), .step_go(step_go),
    .timer_en(timer_en), .io_refresh_en(io_refresh_en), .ext_out(ext_out), .clr(clr),
    .init_io(init_io), .prep(prep), .save_file(save_file), .sys_save(sys_save),
    .wdt_err(wdt_err));
  prmc_engine_model #(.SCAN_CYC(40)) prmc_engine_model_i (
    .pclk(pclk), .presetn(presetn), .exec_en(exec_en), .restart(restart),
    .hang(hang), .scan_end(scan_end));
  always #5 pclk = ~pclk;
  // Pulses are one cycle wide, so latch them for later checks
  always @(posedge pclk)
    seen <= (seen_clr ? 10'h000 : seen)
          | {restart, step_go, init_io, prep, save_file, sys_save, clr};
  task automatic give_verdict;
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits on pready without assuming a latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    if (i == 50) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk(e, experr);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wx(input logic v);
    int i;
    for (i = 0; i < 200 && exec_en !== v; i++) @(posedge pclk);
    chk(exec_en, v);
  endtask
  // Clear on a rising edge so stimulus that follows stays edge aligned
  task automatic clr_seen;
    seen_clr <= 1'b1;
    @(posedge pclk);
    seen_clr <= 1'b0;
  endtask
  initial begin
    cyc(10);
    presetn <= 1'b1;
    cyc(3);
    chk(op_mode, OP_STOP);
    rd(OFS_STATUS, {26'h0, ST_STOP, 1'b0, OP_STOP}, 1'b0);
    rd(OFS_CTRL, 32'h1, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(OFS_OUTIMG, 32'h1234);
    rd(OFS_OUTIMG, 32'h0, 1'b0);
    chk(io_refresh_en, 1'b1);
    // Remote latch clear, all-device clear, then key latch clear
    clr_seen();
    wr(OFS_CMD, 32'h2);
    cyc(3);
    chk(seen[3:0], 4'h5);
    clr_seen();
    wr(OFS_CMD, 32'h4);
    cyc(3);
    chk(seen[3:1], 3'h7);
    clr_seen();
    key.lclr <= 1'b1;
    cyc(1);
    key.lclr <= 1'b0;
    cyc(3);
    chk(seen[3:0], 4'h5);
    // Stop to run: start delay, restart at step 0, prep without I/O init
    key.run <= 1'b1;
    clr_seen();
    wr(OFS_CTRL, 32'h0);
    cyc(15);
    chk(exec_en, 1'b0);
    chk(op_mode, OP_RUN);
    wx(1'b1);
    cyc(1); // Latched pulses settle one edge later
    chk(seen[9], 1'b1);
    chk({seen[7], seen[6]}, 2'b01);
    wr(OFS_OUTIMG, 32'hA5A5);
    cyc(2);
    chk(ext_out, 16'hA5A5);
    // Key stop mid-scan drains to the terminator
    @(posedge scan_end);
    key.stop <= 1'b1;
    cyc(5);
    chk(exec_en, 1'b1);
    wx(1'b0);
    cyc(2);
    chk(op_mode, OP_STOP);
    chk(ext_out, 16'h0);
    chk(io_refresh_en, 1'b1);
    rd(OFS_OUTIMG, 32'hA5A5, 1'b0);
    clr_seen();
    key.stop <= 1'b0;
    wx(1'b1);
    cyc(1);
    chk(ext_out, 16'hA5A5);
    chk({seen[9], seen[7]}, 2'b10);
    // Pause then stepping
    wr(OFS_CTRL, 32'h2);
    wx(1'b0);
    cyc(3);
    chk({op_mode, ext_out}, {OP_PAUSE, 16'hA5A5});
    chk(io_refresh_en, 1'b1);
    wr(OFS_CTRL, 32'h3);
    clr_seen();
    wr(OFS_CMD, 32'h1);
    cyc(3);
    chk({op_mode, seen[8], ext_out}, {OP_STEP, 1'b1, 16'hA5A5});
    // Short outage with chart continuation designated
    wr(OFS_CTRL, 32'h8);
    wx(1'b1);
    clr_seen();
    pf_detect <= 1'b1;
    supply_ok <= 1'b0;
    cyc(4);
    chk({exec_en, timer_en, ext_out}, {2'b01, 16'hA5A5});
    chk(seen[5:4], 2'b11);
    chk(io_refresh_en, 1'b0);
    cyc(6);
    pf_detect <= 1'b0;
    supply_ok <= 1'b1;
    cyc(3);
    chk(exec_en, 1'b1);
    // Long outage gives a full restart
    clr_seen();
    pf_detect <= 1'b1;
    supply_ok <= 1'b0;
    cyc(50);
    pf_detect <= 1'b0;
    supply_ok <= 1'b1;
    cyc(5);
    chk({seen[7], seen[3]}, 2'b11);
    // Runaway scan trips the watchdog
    wr(OFS_CTRL, 32'h0);
    wx(1'b1);
    hang <= 1'b1;
    cyc(230);
    chk(wdt_err, 1'b1);
    hang <= 1'b0;
    wr(OFS_CMD, 32'h8);
    cyc(2);
    chk(wdt_err, 1'b0);
    // Key reset clears general data and reinitialises I/O
    clr_seen();
    key.rst <= 1'b1;
    cyc(1);
    key.rst <= 1'b0;
    cyc(4);
    chk({seen[7], seen[3], seen[2], seen[1]}, 4'b1100);
    give_verdict();
  end
  // Whole sequence needs several hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
